// ===== design/bss_boot_select.v
`timescale 1ns/10ps
`include "bss_defs.vh"
module bss_boot_select (
  core_clk,
  rst,
  strap_a_pin,
  strap_b_pin,
  strap_c_pin,
  prog_mode,
  prog_wr,
  prog_rd,
  prog_erase_all,
  prog_wdata,
  prog_rdata,
  prog_access_ok,
  chip_ctrl_wr,
  chip_ctrl_wdata,
  bank_sel_wr,
  bank_sel_wdata,
  cpu_idle,
  update_done,
  code_rd_from_ext,
  code_rd_target_int,
  boot_region,
  cpu_reset_req,
  update_busy,
  update_bank,
  chip_ctrl_reg,
  code_rd_int_allow,
  clk_high_range
);
  input                     core_clk;
  input                     rst;
  input                     strap_a_pin;
  input                     strap_b_pin;
  input                     strap_c_pin;
  input                     prog_mode;
  input                     prog_wr;
  input                     prog_rd;
  input                     prog_erase_all;
  input  [`BSS_OPT_W-1:0]   prog_wdata;
  output [`BSS_OPT_W-1:0]   prog_rdata;
  output                    prog_access_ok;
  input                     chip_ctrl_wr;
  input  [`BSS_CHIP_W-1:0]  chip_ctrl_wdata;
  input                     bank_sel_wr;
  input                     bank_sel_wdata;
  input                     cpu_idle;
  input                     update_done;
  input                     code_rd_from_ext;
  input                     code_rd_target_int;
  output                    boot_region;
  output                    cpu_reset_req;
  output                    update_busy;
  output                    update_bank;
  output [`BSS_CHIP_W-1:0]  chip_ctrl_reg;
  output                    code_rd_int_allow;
  output                    clk_high_range;

  // ----------------------------------------
  // Strap synchronisers
  // ----------------------------------------
  reg  [`BSS_STRAP_N-1:0] sync1_r;
  reg  [`BSS_STRAP_N-1:0] sync2_r;
  reg  [`BSS_STRAP_N-1:0] sync3_r;
  reg  [`BSS_STRAP_N-1:0] strap_r;
  wire [`BSS_STRAP_N-1:0] pins;
  genvar                  gi;

  assign pins = {strap_c_pin, strap_b_pin, strap_a_pin};

  generate
    for (gi = 0; gi < `BSS_STRAP_N; gi = gi + 1) begin : g_sync
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          sync1_r[gi] <= 1'b1;
          sync2_r[gi] <= 1'b1;
          sync3_r[gi] <= 1'b1;
          strap_r[gi] <= 1'b1;
        end else begin
          sync1_r[gi] <= pins[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          // Change counts only once two stages agree
          if (sync2_r[gi] == sync3_r[gi]) begin
            strap_r[gi] <= sync3_r[gi];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Option bits
  // ----------------------------------------
  reg  [`BSS_OPT_W-1:0] opt_r;
  reg  [`BSS_OPT_W-1:0] opt_nxt;
  reg  [`BSS_OPT_W-1:0] prog_rdata_r;
  reg                   prog_ok_r;
  wire                  locked;
  wire                  opt_access;

  assign locked     = ~opt_r[`BSS_OPT_LOCK];
  assign opt_access = prog_mode & ~locked;

  // Bits only fall; full erase alone raises them
  always @* begin
    opt_nxt = opt_r;
    if (prog_mode && prog_erase_all) begin
      opt_nxt = `BSS_OPT_ERASED;
    end else if (opt_access && prog_wr) begin
      opt_nxt = opt_r & prog_wdata;
    end
  end

  // Nonvolatile: reset pin leaves them alone, else the
  // reboot options could never act at the next reset
  always @(posedge core_clk) begin
    opt_r <= opt_nxt;
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prog_rdata_r <= `BSS_OPT_ERASED;
      prog_ok_r    <= 1'b0;
    end else begin
      prog_ok_r <= opt_access;
      if (opt_access && prog_rd) begin
        prog_rdata_r <= opt_r;
      end else if (!opt_access) begin
        prog_rdata_r <= `BSS_OPT_ERASED;
      end
    end
  end

  // ----------------------------------------
  // Boot capture at reset release
  // ----------------------------------------
  reg                      boot_armed_r;
  reg  [`BSS_SETTLE_W-1:0] settle_r;
  wire                     hw_reboot;
  wire                     settle_done;

  // Straps sampled after release; reset pin is high by then in the table sense
  assign hw_reboot =
    (~opt_r[`BSS_OPT_REBOOT_AB] &
     ~strap_r[`BSS_STRAP_A] & ~strap_r[`BSS_STRAP_B]) |
    (~opt_r[`BSS_OPT_REBOOT_C] & ~strap_r[`BSS_STRAP_C]);
  assign settle_done = boot_armed_r & (settle_r == `BSS_SETTLE_LAST);

  // Decide only after the strap filter has passed the pin levels
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      boot_armed_r <= 1'b1;
      settle_r     <= {`BSS_SETTLE_W{1'b0}};
    end else if (boot_armed_r) begin
      settle_r <= settle_r + 1'b1;
      if (settle_done) begin
        boot_armed_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // ISP control
  // ----------------------------------------
  localparam [1:0] ST_RUN    = `BSS_ST_RUN;
  localparam [1:0] ST_UPDATE = `BSS_ST_UPDATE;

  reg [1:0]             state_r;
  reg [`BSS_CHIP_W-1:0] chip_r;
  reg                   bank_r;
  reg                   rst_req_r;
  reg                   busy_r;
  reg                   cinh_r;
  reg                   clkhi_r;
  reg                   region_r;
  wire                  chip_run;
  wire                  sw_reboot;
  wire                  idle_loader;
  wire                  idle_update;

  // Same compare serves both idle actions
  function chip_is;
    input [`BSS_CHIP_W-1:0] value;
    input [`BSS_CHIP_W-1:0] code;
    begin
      chip_is = (value == code);
    end
  endfunction

  assign chip_run    = ~boot_armed_r & (state_r == ST_RUN);
  assign sw_reboot   = chip_run & chip_ctrl_wr &
                       chip_ctrl_wdata[`BSS_CHIP_SWREBOOT];
  assign idle_loader = chip_run & ~chip_ctrl_wr & cpu_idle &
                       chip_is(chip_r, `BSS_CHIP_TO_LOADER);
  assign idle_update = chip_run & ~chip_ctrl_wr & cpu_idle &
                       chip_is(chip_r, `BSS_CHIP_UPDATE);

  // ----------------------------------------
  // Boot region
  // ----------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      region_r <= `BSS_REGION_MAIN;
    end else if (settle_done) begin
      region_r <= hw_reboot ? `BSS_REGION_LOADER : `BSS_REGION_MAIN;
    end else if (sw_reboot) begin
      region_r <= `BSS_REGION_MAIN;
    end else if (idle_loader) begin
      region_r <= `BSS_REGION_LOADER;
    end
  end

  // Bank writes from main code are ignored
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bank_r <= `BSS_BANK_RST_VAL;
    end else if (!boot_armed_r && bank_sel_wr && region_r == `BSS_REGION_LOADER) begin
      bank_r <= bank_sel_wdata;
    end
  end

  // ----------------------------------------
  // Chip control state
  // ----------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r   <= ST_RUN;
      chip_r    <= `BSS_CHIP_RST_VAL;
      rst_req_r <= 1'b0;
      busy_r    <= 1'b0;
    end else begin
      rst_req_r <= sw_reboot | idle_loader;
      if (!boot_armed_r) begin
        case (state_r)
          ST_RUN: begin
            if (sw_reboot || idle_loader) begin
              chip_r <= `BSS_CHIP_RST_VAL;
            end else if (chip_ctrl_wr) begin
              chip_r <= chip_ctrl_wdata;
            end else if (idle_update) begin
              busy_r  <= 1'b1;
              state_r <= ST_UPDATE;
            end
          end
          ST_UPDATE: begin
            if (update_done) begin
              busy_r  <= 1'b0;
              chip_r  <= `BSS_CHIP_RST_VAL;
              state_r <= ST_RUN;
            end
          end
          default: begin
            state_r <= ST_RUN;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Code-read guard and clock range
  // ----------------------------------------
  // One cycle late; the core must wait for it
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cinh_r <= 1'b1;
    end else begin
      cinh_r <= ~code_rd_target_int | ~code_rd_from_ext |
                opt_r[`BSS_OPT_CODE_INH];
    end
  end

  // Only mirrored; the programmer picks the value
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clkhi_r <= 1'b1;
    end else begin
      clkhi_r <= opt_r[`BSS_OPT_CLK_HI];
    end
  end

  assign prog_rdata        = prog_rdata_r;
  assign prog_access_ok    = prog_ok_r;
  assign boot_region       = region_r;
  assign cpu_reset_req     = rst_req_r;
  assign update_busy       = busy_r;
  assign update_bank       = bank_r;
  assign chip_ctrl_reg     = chip_r;
  assign code_rd_int_allow = cinh_r;
  assign clk_high_range    = clkhi_r;
endmodule

// ===== shared/bss_defs.vh
`ifndef BSS_DEFS_VH
`define BSS_DEFS_VH
`define BSS_OPT_W          8
`define BSS_OPT_ERASED     8'hff
`define BSS_OPT_LOCK       0
`define BSS_OPT_CODE_INH   1
`define BSS_OPT_REBOOT_AB  4
`define BSS_OPT_REBOOT_C   5
`define BSS_OPT_CLK_HI     7
`define BSS_CHIP_W         8
`define BSS_CHIP_RST_VAL   8'h00
`define BSS_CHIP_TO_LOADER 8'h03
`define BSS_CHIP_UPDATE    8'h01
`define BSS_CHIP_SWREBOOT  7
`define BSS_BANK_RST_VAL   1'b0
`define BSS_REGION_MAIN    1'b0
`define BSS_REGION_LOADER  1'b1
`define BSS_ST_RUN         2'h0
`define BSS_ST_UPDATE      2'h1
`define BSS_ST_RESET       2'h2
`define BSS_STRAP_N        3
`define BSS_STRAP_A        0
`define BSS_STRAP_B        1
`define BSS_STRAP_C        2
`define BSS_SETTLE_W       3
`define BSS_SETTLE_LAST    3'h4
`endif

// ===== sim/bss_boot_select_props.sv
`timescale 1ns/10ps
module bss_boot_select_props (
  input logic       core_clk,
  input logic       rst,
  input logic       prog_mode,
  input logic [7:0] prog_rdata,
  input logic       prog_access_ok,
  input logic       chip_ctrl_wr,
  input logic [7:0] chip_ctrl_wdata,
  input logic       bank_sel_wr,
  input logic       cpu_idle,
  input logic       code_rd_from_ext,
  input logic       boot_region,
  input logic       cpu_reset_req,
  input logic       update_busy,
  input logic       update_bank,
  input logic [7:0] chip_ctrl_reg,
  input logic       code_rd_int_allow
);
  logic [2:0] since_rst;
  // Boot decision moves the region on its own after release
  always @(posedge core_clk or posedge rst) begin
    if (rst) since_rst <= 3'h0;
    else if (since_rst != 3'h7) since_rst <= since_rst + 3'h1;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ------
  // Checks
  // ------
  a_reset_one_cycle: assert property (cpu_reset_req |=> !cpu_reset_req)
    else $error("reset request too long");
  a_idle_to_loader: assert property (chip_ctrl_reg == 8'h03 && cpu_idle && !chip_ctrl_wr
    && !update_busy |=> boot_region && cpu_reset_req) else $error("no switch to loader");
  a_idle_update: assert property (chip_ctrl_reg == 8'h01 && cpu_idle && !chip_ctrl_wr
    && !update_busy |=> update_busy && $stable(boot_region)) else $error("update start wrong");
  a_progmode_off: assert property (!prog_mode |=> !prog_access_ok)
    else $error("access without programmer mode");
  a_swreboot_main: assert property (chip_ctrl_wr && chip_ctrl_wdata[7] && !update_busy
    |-> ##[1:2] (cpu_reset_req && !boot_region)) else $error("no reboot to main");
  a_internal_read: assert property (!code_rd_from_ext |=> code_rd_int_allow)
    else $error("internal code read refused");
  a_progmode_gate: assert property ($fell(prog_mode) |-> ##[1:2] !prog_access_ok)
    else $error("access kept outside programmer mode");
  a_no_access_ff: assert property (!prog_access_ok && !$past(prog_access_ok)
    |-> prog_rdata == 8'hff) else $error("option data leaked");
  a_bank_loader: assert property (bank_sel_wr && !boot_region |=> $stable(update_bank))
    else $error("bank changed from main");
  a_region_held: assert property (since_rst == 3'h7 && !cpu_idle && !chip_ctrl_wr
    |=> $stable(boot_region)) else $error("boot region moved");
  c_loader: cover property (cpu_idle && chip_ctrl_reg == 8'h03);
  c_update: cover property ($rose(update_busy));
  c_guard: cover property (!code_rd_int_allow);
  c_hw_reboot: cover property (since_rst == 3'h6 && boot_region);
endmodule
bind bss_boot_select bss_boot_select_props bss_boot_select_props_i (.*);

// ===== sim/bss_boot_select_tb_top.sv
`timescale 1ns/10ps
module bss_boot_select_tb_top;
  logic       core_clk, rst, prog_mode, bank_sel_wdata, code_rd_from_ext, code_rd_target_int;
  logic       strap_a_pin, strap_b_pin, strap_c_pin, prog_access_ok, boot_region;
  logic       cpu_reset_req, update_busy, update_bank, code_rd_int_allow, clk_high_range;
  logic       chip_ctrl_wr, prog_rd, prog_wr, prog_erase_all, update_done, bank_sel_wr, cpu_idle;
  logic       jumper_ab, jumper_c;
  logic [6:0] stb;
  logic [7:0] prog_wdata, prog_rdata, chip_ctrl_wdata, chip_ctrl_reg, clk_opt;
  int         miscompares = 0;
  int         cmp_count = 0;
  assign {chip_ctrl_wr, prog_rd, prog_wr, prog_erase_all, update_done, bank_sel_wr, cpu_idle} = stb;
  bss_boot_select bss_boot_select_i (.*);
  bss_far_side bss_far_side_i (.*);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One-cycle strobe; data rides along on every data input
  task automatic strobe(input logic [6:0] m, input logic [7:0] d);
    @(posedge core_clk);
    stb             <= m;
    prog_wdata      <= d;
    chip_ctrl_wdata <= d;
    bank_sel_wdata  <= d[0];
    @(posedge core_clk);
    stb <= 7'h00;
    #1;
  endtask
  task automatic guard(input logic e, input logic t, input logic [7:0] x);
    @(posedge core_clk);
    code_rd_from_ext   <= e;
    code_rd_target_int <= t;
    repeat (2) @(posedge core_clk);
    #1;
    chk("code_rd_int_allow", x, code_rd_int_allow);
  endtask
  // Mid-run reset with jumpers set; option cells keep their value
  task automatic reset_boot(input logic ab, input logic c, input logic [7:0] x);
    @(posedge core_clk);
    rst       <= 1'b1;
    jumper_ab <= ab;
    jumper_c  <= c;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (7) @(posedge core_clk);
    #1;
    chk("boot_region", x, boot_region);
    chk("cpu_reset_req", 8'h00, cpu_reset_req);
  endtask
  task automatic opt_rd(input logic [7:0] x);
    strobe(7'h20, 8'h00);
    chk("prog_rdata", x, prog_rdata);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ------
  // Tests
  // ------
  initial begin
    // Option cells start unknown: full erase while reset is held
    {rst, stb, prog_mode, prog_wdata, chip_ctrl_wdata} = {1'b1, 7'h08, 1'b1, 16'h0};
    {bank_sel_wdata, code_rd_from_ext, code_rd_target_int} = 3'h1;
    {jumper_ab, jumper_c} = 2'h0;
    @(posedge core_clk);
    stb       <= 7'h00;
    prog_mode <= 1'b0;
    @(posedge core_clk);
    rst <= 1'b0;
    repeat (7) @(posedge core_clk);
    #1;
    chk("boot_region", 8'h00, boot_region);
    chk("clk_high_range", 8'h01, clk_high_range);
    opt_rd(8'hff);
    @(posedge core_clk);
    prog_mode <= 1'b1;
    strobe(7'h10, clk_opt & 8'hfd);
    opt_rd(8'hfd);
    chk("clk_high_range", 8'h01, clk_high_range);
    strobe(7'h10, 8'hff);
    opt_rd(8'hfd);
    guard(1'b1, 1'b1, 8'h00);
    guard(1'b1, 1'b0, 8'h01);
    guard(1'b0, 1'b1, 8'h01);
    strobe(7'h10, 8'hfe);
    opt_rd(8'hff);
    chk("prog_access_ok", 8'h00, prog_access_ok);
    strobe(7'h08, 8'h00);
    opt_rd(8'hff);
    chk("prog_access_ok", 8'h01, prog_access_ok);
    guard(1'b1, 1'b1, 8'h01);
    strobe(7'h40, 8'h03);
    chk("chip_ctrl_reg", 8'h03, chip_ctrl_reg);
    strobe(7'h01, 8'h00);
    chk("boot_region", 8'h01, boot_region);
    chk("cpu_reset_req", 8'h01, cpu_reset_req);
    strobe(7'h02, 8'h01);
    chk("update_bank", 8'h01, update_bank);
    strobe(7'h40, 8'h80);
    chk("boot_region", 8'h00, boot_region);
    chk("cpu_reset_req", 8'h01, cpu_reset_req);
    strobe(7'h02, 8'h00);
    chk("update_bank", 8'h01, update_bank);
    strobe(7'h40, 8'h01);
    strobe(7'h01, 8'h00);
    chk("update_busy", 8'h01, update_busy);
    strobe(7'h04, 8'h00);
    chk("boot_region", 8'h00, boot_region);
    chk("update_busy", 8'h00, update_busy);
    chk("chip_ctrl_reg", 8'h00, chip_ctrl_reg);
    strobe(7'h10, 8'hef);
    @(posedge core_clk);
    prog_mode <= 1'b0;
    opt_rd(8'hff);
    chk("prog_access_ok", 8'h00, prog_access_ok);
    reset_boot(1'b1, 1'b0, 8'h01);
    reset_boot(1'b0, 1'b1, 8'h00);
    @(posedge core_clk);
    prog_mode <= 1'b1;
    strobe(7'h10, 8'hdf);
    reset_boot(1'b0, 1'b1, 8'h01);
    reset_boot(1'b0, 1'b0, 8'h00);
    tally_and_finish();
  end
  // Hang guard: far beyond the longest sequence above
  initial begin
    #100us;
    miscompares++;
    tally_and_finish();
  end
endmodule

// ===== sim/bss_far_side.sv
`timescale 1ns/10ps
module bss_far_side #(
  parameter int XT_MHZ = 40
) (
  input  logic       jumper_ab,
  input  logic       jumper_c,
  output logic       strap_a_pin,
  output logic       strap_b_pin,
  output logic       strap_c_pin,
  output logic [7:0] clk_opt
);
  // Pull-ups: straps read high unless a jumper is fitted
  assign strap_a_pin = ~jumper_ab;
  assign strap_b_pin = ~jumper_ab;
  assign strap_c_pin = ~jumper_c;
  assign clk_opt = (XT_MHZ > 24) ? 8'hff : 8'h7f;
endmodule
